// >>> hdl/lpfd_pkg.sv
package lpfd_pkg;

    localparam int NUM_CH = 4;
    localparam int CNT_W = 20;
    localparam int CH_BITS = 1 + 2 * CNT_W;
    localparam int FRAME_BITS = NUM_CH * CH_BITS;
    localparam int NBITS_W = 8;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned PWM_TICK_HZ = 2_000_000;
    localparam int unsigned TICK_DIV = CLK_HZ / PWM_TICK_HZ;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned UPDATE_NS = 200_000;
    localparam int unsigned UPDATE_CYC = UPDATE_NS / CLK_PERIOD_NS;
    localparam int STALE_W = 13;

    localparam logic [3:0] REG_FLAGS = 4'h0;
    localparam logic [3:0] REG_FLAG_CLR = 4'h1;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
    localparam logic [3:0] REG_IRQ_CLR = 4'h3;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h5;
    localparam logic [3:0] REG_STATE = 4'h6;

    localparam int FLG_LS_OPEN = 0;
    localparam int FLG_LS_SHORT = 4;
    localparam int FLG_INJ_OPEN = 8;
    localparam int FLG_INJ_SHORT = 12;
    localparam int FLG_W = 16;
    localparam int IRQ_STALE = 16;
    localparam int IRQ_FRAME_ERR = 17;
    localparam int IRQ_W = 18;

    localparam int ST_LS_DRIVE = 0;
    localparam int ST_INJ_DRIVE = 4;
    localparam int ST_SUPERVISED = 8;
    localparam int ST_STALE = 9;
    localparam int ST_ARMED = 10;

    localparam logic CTRL_ARM_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 18'h00000;

endpackage : lpfd_pkg

// >>> hdl/lpfd_ser_rx.sv
`timescale 1ns/100ps
module lpfd_ser_rx #(
    parameter int NUM_CH = lpfd_pkg::NUM_CH,
    parameter int CNT_W = lpfd_pkg::CNT_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial parameter link
    input wire logic ser_frame,
    input wire logic ser_bit,
    // Decoded parameters
    output logic [NUM_CH-1:0] rx_en,
    output logic [NUM_CH-1:0][CNT_W-1:0] rx_period,
    output logic [NUM_CH-1:0][CNT_W-1:0] rx_high,
    output logic rx_upd,
    output logic rx_err
);

    localparam int CHB = 1 + 2 * CNT_W;
    localparam int FB = NUM_CH * CHB;

    typedef struct packed {
        logic [FB-1:0] shift;
        logic [lpfd_pkg::NBITS_W-1:0] nbits;
        logic in_frame;
        logic [NUM_CH-1:0] en;
        logic [NUM_CH-1:0][CNT_W-1:0] period;
        logic [NUM_CH-1:0][CNT_W-1:0] high;
        logic upd;
        logic err;
    } lpfd_rx_state_t;

    lpfd_rx_state_t s;
    lpfd_rx_state_t next_s;

    // The first bit of a frame is channel 0 enable; a frame of the wrong length is dropped whole.
    always_comb
    begin
        int base;
        base = 0;
        next_s = s;
        next_s.upd = 1'b0;
        next_s.err = 1'b0;
        next_s.in_frame = ser_frame;
        if (ser_frame)
        begin
            next_s.shift = {s.shift[FB-2:0], ser_bit};
            if (!s.in_frame)
                next_s.nbits = lpfd_pkg::NBITS_W'(1);
            else if (s.nbits != '1)
                next_s.nbits = s.nbits + lpfd_pkg::NBITS_W'(1);
        end
        else if (s.in_frame)
        begin
            if (s.nbits == lpfd_pkg::NBITS_W'(FB))
            begin
                next_s.upd = 1'b1;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    base = FB - 1 - c * CHB;
                    next_s.en[c] = s.shift[base];
                    next_s.period[c] = s.shift[base-1 -: CNT_W];
                    next_s.high[c] = s.shift[base-1-CNT_W -: CNT_W];
                end
            end
            else
                next_s.err = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign rx_en = s.en;
    assign rx_period = s.period;
    assign rx_high = s.high;
    assign rx_upd = s.upd;
    assign rx_err = s.err;

endmodule : lpfd_ser_rx

// >>> hdl/lpfd_driver.sv
// Notes on behaviour
// - Injector short detection disables channel until software clears the flag.
// - Each low-side channel has its own PWM covering 0 to 100 percent.
// - Enable, period and high time arrive serially every 200 us.
// - PWM counters are 20 bits wide and step at 2 MHz.
// - Zero duty holds the output off, full duty holds it on.
// - While commanded off, an open load sets the open flag.
// - Software clears open flags; a set open flag never affects switching.
// - While commanded on, a short sets the flag and disables the channel.
// - Short flag clear is ignored while the channel is commanded on.
// - No injector pulse without the engine position supervision input.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
module lpfd_driver #(
    parameter int NUM_CH = lpfd_pkg::NUM_CH,
    parameter int CNT_W = lpfd_pkg::CNT_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial parameter link from the host
    input wire logic ser_frame,
    input wire logic ser_bit,
    // Low-side channels
    input wire logic [NUM_CH-1:0] ls_open_sense,
    input wire logic [NUM_CH-1:0] ls_short_sense,
    output logic [NUM_CH-1:0] ls_drive,
    // Injector channels
    input wire logic [NUM_CH-1:0] inj_fuel_req,
    input wire logic [NUM_CH-1:0] inj_hold_reached,
    input wire logic [NUM_CH-1:0] inj_short_sense,
    input wire logic engine_position_supervision_input,
    output logic [NUM_CH-1:0] inj_drive,
    // Interrupt
    output logic irq
);

    localparam int TICK_LAST = int'(lpfd_pkg::TICK_DIV) - 1;
    localparam int UPD_CYC = int'(lpfd_pkg::UPDATE_CYC);

    typedef struct packed {
        logic [3:0] prescale;
        logic tick;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
        logic [NUM_CH-1:0] pwm_on;
        logic [NUM_CH-1:0] ls_drive;
        logic [NUM_CH-1:0] ls_open;
        logic [NUM_CH-1:0] ls_short;
        logic [NUM_CH-1:0] inj_on;
        logic [NUM_CH-1:0] inj_hold_seen;
        logic [NUM_CH-1:0] inj_open;
        logic [NUM_CH-1:0] inj_short;
        logic [NUM_CH-1:0] inj_drive;
        logic [lpfd_pkg::IRQ_W-1:0] irq_status;
        logic [lpfd_pkg::IRQ_W-1:0] irq_enable;
        logic ctrl_arm;
        logic [lpfd_pkg::STALE_W-1:0] stale_cnt;
        logic stale;
        logic irq;
        logic [31:0] rdata;
    } lpfd_state_t;

    lpfd_state_t s;
    lpfd_state_t next_s;

    logic [NUM_CH-1:0] rx_en;
    logic [NUM_CH-1:0][CNT_W-1:0] rx_period;
    logic [NUM_CH-1:0][CNT_W-1:0] rx_high;
    logic rx_upd;
    logic rx_err;

    lpfd_ser_rx #(
        .NUM_CH(NUM_CH),
        .CNT_W(CNT_W)
    ) u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ser_frame(ser_frame),
        .ser_bit(ser_bit),
        .rx_en(rx_en),
        .rx_period(rx_period),
        .rx_high(rx_high),
        .rx_upd(rx_upd),
        .rx_err(rx_err)
    );

    // A set always beats a clear arriving in the same cycle.
    function automatic logic [NUM_CH-1:0] flag_step(
        input logic [NUM_CH-1:0] flag,
        input logic [NUM_CH-1:0] set,
        input logic [NUM_CH-1:0] clr
    );
        flag_step = (flag & ~clr) | set;
    endfunction : flag_step

    always_comb
    begin
        logic [CNT_W-1:0] inc;
        logic [NUM_CH-1:0] clr_ls_open;
        logic [NUM_CH-1:0] clr_ls_short;
        logic [NUM_CH-1:0] clr_inj_open;
        logic [NUM_CH-1:0] clr_inj_short;
        logic [NUM_CH-1:0] inj_end_open;
        logic [lpfd_pkg::FLG_W-1:0] flags_now;
        logic [lpfd_pkg::FLG_W-1:0] flags_next;
        logic [lpfd_pkg::IRQ_W-1:0] events;
        logic [lpfd_pkg::IRQ_W-1:0] irq_clr;
        logic wr_flag_clr;
        inc = '0;
        wr_flag_clr = reg_wr && (reg_addr == lpfd_pkg::REG_FLAG_CLR);
        clr_ls_open = wr_flag_clr ? reg_wdata[lpfd_pkg::FLG_LS_OPEN +: NUM_CH] : '0;
        clr_ls_short = wr_flag_clr ? reg_wdata[lpfd_pkg::FLG_LS_SHORT +: NUM_CH] : '0;
        clr_inj_open = wr_flag_clr ? reg_wdata[lpfd_pkg::FLG_INJ_OPEN +: NUM_CH] : '0;
        clr_inj_short = wr_flag_clr ? reg_wdata[lpfd_pkg::FLG_INJ_SHORT +: NUM_CH] : '0;
        irq_clr = (reg_wr && reg_addr == lpfd_pkg::REG_IRQ_CLR) ? reg_wdata[lpfd_pkg::IRQ_W-1:0] : '0;
        next_s = s;

        // The 2 MHz step is a one-cycle tick every tenth core clock.
        next_s.tick = (s.prescale == 4'(TICK_LAST));
        next_s.prescale = next_s.tick ? 4'h0 : s.prescale + 4'h1;

        for (int c = 0; c < NUM_CH; c++)
        begin
            inc = s.cnt[c] + CNT_W'(1);
            if (!rx_en[c])
                next_s.cnt[c] = '0;
            else if (s.tick)
                next_s.cnt[c] = (inc >= rx_period[c]) ? '0 : inc;
            // High time zero never compares above the counter; high time at or above
            // the period never falls below it, so both ends of the duty range hold.
            next_s.pwm_on[c] = rx_en[c] && (next_s.cnt[c] < rx_high[c]);
        end

        // Faults are judged against the registered command; the low-side switch gets it one cycle later, the injector in the same cycle.
        // Low-side faults: open is tested while off, short while on.
        next_s.ls_open = flag_step(s.ls_open, ~s.pwm_on & ls_open_sense, clr_ls_open);
        next_s.ls_short = flag_step(s.ls_short, s.pwm_on & ls_short_sense,
                                    clr_ls_short & ~s.pwm_on);
        // The open flag takes no part in the drive term.
        next_s.ls_drive = s.pwm_on & ~next_s.ls_short;

        // Injector commands pass only under engine position supervision.
        next_s.inj_on = inj_fuel_req & {NUM_CH{engine_position_supervision_input && s.ctrl_arm}};
        // Hold is remembered over the whole event, since the sense may drop once current control starts.
        next_s.inj_hold_seen = s.inj_on & (s.inj_hold_seen | inj_hold_reached);
        inj_end_open = s.inj_on & ~next_s.inj_on & ~(s.inj_hold_seen | inj_hold_reached);
        next_s.inj_open = flag_step(s.inj_open, inj_end_open, clr_inj_open);
        next_s.inj_short = flag_step(s.inj_short, s.inj_on & inj_short_sense,
                                     clr_inj_short & ~s.inj_on);
        next_s.inj_drive = next_s.inj_on & ~next_s.inj_short;

        // Parameter freshness watchdog.
        // It stops at its terminal count rather than wrapping, so a long silence can never clear it.
        if (rx_upd)
        begin
            next_s.stale_cnt = '0;
            next_s.stale = 1'b0;
        end
        else if (s.stale_cnt != lpfd_pkg::STALE_W'(UPD_CYC))
            next_s.stale_cnt = s.stale_cnt + lpfd_pkg::STALE_W'(1);
        else
            next_s.stale = 1'b1;

        // Flag and stale events are rising edges, so a flag that stays set reports only once; a frame error reports on every bad frame.
        flags_now = {s.inj_short, s.inj_open, s.ls_short, s.ls_open};
        flags_next = {next_s.inj_short, next_s.inj_open, next_s.ls_short, next_s.ls_open};
        events = {rx_err, next_s.stale & ~s.stale, flags_next & ~flags_now};
        next_s.irq_status = (s.irq_status & ~irq_clr) | events;

        if (reg_wr && reg_addr == lpfd_pkg::REG_IRQ_ENABLE)
            next_s.irq_enable = reg_wdata[lpfd_pkg::IRQ_W-1:0];
        if (reg_wr && reg_addr == lpfd_pkg::REG_CTRL)
            next_s.ctrl_arm = reg_wdata[0];
        next_s.irq = |(next_s.irq_status & next_s.irq_enable);

        // Read data are zero outside the answer cycle, which keeps a shared read bus quiet.
        next_s.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                lpfd_pkg::REG_FLAGS: next_s.rdata = 32'(flags_now);
                lpfd_pkg::REG_IRQ_STATUS: next_s.rdata = 32'(s.irq_status);
                lpfd_pkg::REG_IRQ_ENABLE: next_s.rdata = 32'(s.irq_enable);
                lpfd_pkg::REG_CTRL: next_s.rdata = 32'(s.ctrl_arm);
                lpfd_pkg::REG_STATE: next_s.rdata = 32'({s.ctrl_arm, s.stale,
                    engine_position_supervision_input, s.inj_drive, s.ls_drive});
                default: next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.irq_enable <= lpfd_pkg::IRQ_ENABLE_RST;
            s.ctrl_arm <= lpfd_pkg::CTRL_ARM_RST;
        end
        else
            s <= next_s;
    end

    assign ls_drive = s.ls_drive;
    assign inj_drive = s.inj_drive;
    assign irq = s.irq;
    assign reg_rdata = s.rdata;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence tick_gap;
        (!s.tick) [*8] ##1 !s.tick ##1 s.tick;
    endsequence

    a_tick_spacing: assert property (s.tick |=> tick_gap)
        else $error("PWM tick spacing is not ten cycles");

    a_stale_timeout: assert property (s.stale_cnt == lpfd_pkg::STALE_W'(UPD_CYC) && !rx_upd |=> s.stale)
        else $error("Missing parameter update was not flagged");

    a_stale_cleared: assert property (rx_upd |=> !s.stale && s.stale_cnt == '0)
        else $error("Parameter update did not restart the watchdog");

    // A prescaler past its terminal count would stretch one tick period to sixteen cycles.
    a_prescale_range: assert property (s.prescale <= 4'(TICK_LAST))
        else $error("PWM prescaler ran past its terminal count");

    a_irq_level: assert property (s.irq == |(s.irq_status & s.irq_enable))
        else $error("Interrupt output disagrees with enabled status");

    a_rdata_idle: assert property (!reg_rd |=> s.rdata == '0)
        else $error("Read data present without a read");

    a_frame_error: assert property (rx_err |=> s.irq_status[lpfd_pkg::IRQ_FRAME_ERR])
        else $error("Bad frame length was not reported");

    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_chk
            sequence disabled_two;
                (!rx_en[i]) [*2];
            endsequence

            a_ls_disabled_off: assert property (disabled_two |=> !s.ls_drive[i])
                else $error("Disabled channel drives its output");

            a_ls_zero_duty: assert property ((rx_en[i] && rx_high[i] == '0) [*2] |=> !s.ls_drive[i])
                else $error("Zero duty channel switched on");

            a_ls_full_duty: assert property (rx_en[i] && rx_high[i] == '1 ##1 1'b1 ##1 !s.ls_short[i]
                |-> s.ls_drive[i])
                else $error("Full duty channel switched off");

            a_ls_open_set: assert property (!s.pwm_on[i] && ls_open_sense[i] |=> s.ls_open[i])
                else $error("Open load while off was not flagged");

            a_ls_open_inert: assert property (s.ls_open[i] && s.pwm_on[i] && !s.ls_short[i]
                && !ls_short_sense[i] |=> s.ls_drive[i])
                else $error("Open flag blocked switching");

            a_ls_short_trip: assert property (s.pwm_on[i] && ls_short_sense[i]
                |=> s.ls_short[i] && !s.ls_drive[i])
                else $error("Short while on did not disable the channel");

            a_ls_short_hold: assert property (s.ls_short[i] && s.pwm_on[i] |=> s.ls_short[i])
                else $error("Short flag cleared while commanded on");

            a_inj_short_trip: assert property (s.inj_on[i] && inj_short_sense[i]
                |=> s.inj_short[i] && !s.inj_drive[i])
                else $error("Injector short did not disable the channel");

            a_inj_supervised: assert property (!engine_position_supervision_input |=> !s.inj_drive[i])
                else $error("Injector fired without supervision");

            a_inj_unarmed: assert property (!s.ctrl_arm |=> !s.inj_drive[i])
                else $error("Injector fired while not armed");

            // Short flags are held only where no clear write can race the set.
            sequence ls_short_kept;
                s.ls_short[i] && !(reg_wr && reg_addr == lpfd_pkg::REG_FLAG_CLR
                    && reg_wdata[lpfd_pkg::FLG_LS_SHORT + i]);
            endsequence

            sequence inj_short_kept;
                s.inj_short[i] && !(reg_wr && reg_addr == lpfd_pkg::REG_FLAG_CLR
                    && reg_wdata[lpfd_pkg::FLG_INJ_SHORT + i]);
            endsequence

            // The counter clears while disabled; otherwise it moves only on a tick and wraps on the period.
            a_cnt_disabled: assert property (!rx_en[i] |=> s.cnt[i] == '0)
                else $error("Disabled channel counter did not clear");

            a_cnt_hold: assert property (rx_en[i] && !s.tick |=> $stable(s.cnt[i]))
                else $error("PWM counter moved between ticks");

            a_cnt_wrap: assert property (rx_en[i] && s.tick
                && CNT_W'(s.cnt[i] + CNT_W'(1)) >= rx_period[i] |=> s.cnt[i] == '0)
                else $error("PWM counter did not wrap at the period");

            a_ls_open_clear: assert property (reg_wr && reg_addr == lpfd_pkg::REG_FLAG_CLR
                && reg_wdata[lpfd_pkg::FLG_LS_OPEN + i] && (s.pwm_on[i] || !ls_open_sense[i])
                |=> !s.ls_open[i])
                else $error("Open flag did not clear");

            a_ls_short_clear: assert property (reg_wr && reg_addr == lpfd_pkg::REG_FLAG_CLR
                && reg_wdata[lpfd_pkg::FLG_LS_SHORT + i] && !s.pwm_on[i] |=> !s.ls_short[i])
                else $error("Short flag clear while off was lost");

            a_ls_short_block: assert property (ls_short_kept |=> !s.ls_drive[i])
                else $error("Channel switched on with its short flag set");

            a_inj_short_hold: assert property (s.inj_short[i] && s.inj_on[i] |=> s.inj_short[i])
                else $error("Injector short flag cleared while commanded on");

            a_inj_short_block: assert property (inj_short_kept |=> !s.inj_drive[i])
                else $error("Injector fired with its short flag set");

            a_inj_open_set: assert property (s.inj_on[i] && !s.inj_hold_seen[i] && !inj_hold_reached[i]
                && !inj_fuel_req[i] |=> s.inj_open[i])
                else $error("Injector event without hold was not flagged open");
        end
    endgenerate

endmodule : lpfd_driver

// >>> bench/lpfd_host_model.sv
`timescale 1ns/100ps
module lpfd_host_model (
    // Clock
    input wire logic core_clk,
    // Serial parameter link
    output logic ser_frame,
    output logic ser_bit
);
    initial
    begin
        ser_frame = 1'b0;
        ser_bit = 1'b0;
    end

    // Outside a frame the data line shows the inverse of the last bit.
    // A receiver that samples it out of frame then cannot pass old data off as valid.
    task automatic send_frame(input logic [lpfd_pkg::FRAME_BITS-1:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            ser_frame <= 1'b1;
            ser_bit <= f[lpfd_pkg::FRAME_BITS-1-i];
        end
        @(posedge core_clk);
        ser_frame <= 1'b0;
        ser_bit <= ~ser_bit;
    endtask : send_frame
endmodule : lpfd_host_model

// >>> bench/tb_lowside_pwm_fault_driver.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module tb_lowside_pwm_fault_driver;
    localparam int W = 40 * int'(lpfd_pkg::TICK_DIV);
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic ser_frame;
    logic ser_bit;
    logic [3:0] ls_open_sense = 4'h0;
    logic [3:0] ls_short_sense = 4'h0;
    logic [3:0] ls_drive;
    logic [3:0] inj_fuel_req = 4'h0;
    logic [3:0] inj_hold_reached = 4'hf;
    logic [3:0] inj_short_sense = 4'h0;
    logic sup = 1'b0;
    logic [3:0] inj_drive;
    logic irq;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int hcnt [4];
    logic [3:0] en = 4'h7;
    logic [19:0] per [4] = '{20'h4, 20'h4, 20'h4, 20'h4};
    logic [19:0] hi [4] = '{20'h2, 20'h0, 20'hfffff, 20'h2};

    lpfd_host_model u_lpfd_host_model (.core_clk(core_clk), .ser_frame(ser_frame), .ser_bit(ser_bit));

    lpfd_driver u_lpfd_driver (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_frame(ser_frame),
        .ser_bit(ser_bit), .ls_open_sense(ls_open_sense), .ls_short_sense(ls_short_sense),
        .ls_drive(ls_drive), .inj_fuel_req(inj_fuel_req), .inj_hold_reached(inj_hold_reached),
        .inj_short_sense(inj_short_sense), .engine_position_supervision_input(sup),
        .inj_drive(inj_drive), .irq(irq)
    );

    always #25 core_clk = ~core_clk;

    task automatic summarize();
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata & m, e)
    endtask : rdchk

    task automatic cfg(input int n);
        logic [lpfd_pkg::FRAME_BITS-1:0] f;
        f = '0;
        for (int c = 0; c < 4; c++)
            f = {f[lpfd_pkg::FRAME_BITS-lpfd_pkg::CH_BITS-1:0], en[c], per[c], hi[c]};
        u_lpfd_host_model.send_frame(f, n);
        wait_cyc(4);
    endtask : cfg

    task automatic measure();
        hcnt = '{0, 0, 0, 0};
        repeat (W)
        begin
            @(posedge core_clk);
            #1;
            for (int c = 0; c < 4; c++)
                hcnt[c] += int'(ls_drive[c]);
        end
    endtask : measure

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cyc(1);
        `CHK(ls_drive, 4'h0)
        rdchk(lpfd_pkg::REG_IRQ_ENABLE, 32'hffffffff, 32'h0);
        rdchk(lpfd_pkg::REG_CTRL, 32'h1, 32'h0);
        rdchk(4'hf, 32'hffffffff, 32'h0);
        wr(lpfd_pkg::REG_FLAG_CLR, 32'hffff);
        wr(lpfd_pkg::REG_IRQ_CLR, 32'h3ffff);
        cfg(lpfd_pkg::FRAME_BITS);
        // Open loads sit on channels that are held off, while duty is measured.
        @(posedge core_clk);
        ls_open_sense <= 4'ha;
        wr(lpfd_pkg::REG_IRQ_ENABLE, 32'h2);
        measure();
        `CHK(hcnt[0], W / 2)
        `CHK(hcnt[1], 0)
        `CHK(hcnt[2], W)
        `CHK(hcnt[3], 0)
        rdchk(lpfd_pkg::REG_FLAGS, 32'hff, 32'h0a);
        `CHK(irq, 1'b1)
        @(posedge core_clk);
        ls_open_sense <= 4'h0;
        wr(lpfd_pkg::REG_FLAG_CLR, 32'ha);
        wr(lpfd_pkg::REG_IRQ_CLR, 32'h3ffff);
        rdchk(lpfd_pkg::REG_FLAGS, 32'hff, 32'h0);
        `CHK(irq, 1'b0)
        @(posedge core_clk);
        ls_short_sense <= 4'h4;
        wait_cyc(4);
        @(posedge core_clk);
        ls_short_sense <= 4'h0;
        wait_cyc(4);
        `CHK(ls_drive[2], 1'b0)
        rdchk(lpfd_pkg::REG_FLAGS, 32'hff, 32'h40);
        wr(lpfd_pkg::REG_FLAG_CLR, 32'h40);
        rdchk(lpfd_pkg::REG_FLAGS, 32'hff, 32'h40);
        en[2] = 1'b0;
        cfg(lpfd_pkg::FRAME_BITS);
        wr(lpfd_pkg::REG_FLAG_CLR, 32'h40);
        rdchk(lpfd_pkg::REG_FLAGS, 32'hff, 32'h0);
        en[2] = 1'b1;
        cfg(lpfd_pkg::FRAME_BITS);
        wait_cyc(4);
        `CHK(ls_drive[2], 1'b1)
        // Injector events carry no peak phase, as for a high-impedance load with peak time zero.
        @(posedge core_clk);
        inj_fuel_req <= 4'h1;
        wr(lpfd_pkg::REG_CTRL, 32'h1);
        wait_cyc(6);
        `CHK(inj_drive, 4'h0)
        @(posedge core_clk);
        sup <= 1'b1;
        wait_cyc(6);
        `CHK(inj_drive, 4'h1)
        @(posedge core_clk);
        inj_short_sense <= 4'h1;
        wait_cyc(6);
        @(posedge core_clk);
        inj_short_sense <= 4'h0;
        wait_cyc(4);
        `CHK(inj_drive, 4'h0)
        // The injector open flags are masked out, high-impedance loads may never reach hold.
        rdchk(lpfd_pkg::REG_FLAGS, 32'hf000, 32'h1000);
        wr(lpfd_pkg::REG_FLAG_CLR, 32'h1000);
        rdchk(lpfd_pkg::REG_FLAGS, 32'hf000, 32'h1000);
        @(posedge core_clk);
        inj_fuel_req <= 4'h0;
        wr(lpfd_pkg::REG_FLAG_CLR, 32'h1000);
        rdchk(lpfd_pkg::REG_FLAGS, 32'hf000, 32'h0);
        @(posedge core_clk);
        inj_fuel_req <= 4'h1;
        wait_cyc(6);
        `CHK(inj_drive, 4'h1)
        rdchk(lpfd_pkg::REG_STATE, 32'h5f0, 32'h510);
        // An event that never reaches hold ends with the open flag set.
        @(posedge core_clk);
        inj_fuel_req <= 4'h0;
        inj_hold_reached <= 4'h0;
        wait_cyc(3);
        @(posedge core_clk);
        inj_fuel_req <= 4'h1;
        wait_cyc(3);
        @(posedge core_clk);
        inj_fuel_req <= 4'h0;
        wait_cyc(3);
        rdchk(lpfd_pkg::REG_FLAGS, 32'h0f00, 32'h0100);
        wr(lpfd_pkg::REG_IRQ_CLR, 32'h3ffff);
        cfg(100);
        rdchk(lpfd_pkg::REG_IRQ_STATUS, 32'h20000, 32'h20000);
        cfg(lpfd_pkg::FRAME_BITS);
        wr(lpfd_pkg::REG_IRQ_CLR, 32'h3ffff);
        wait_cyc(3000);
        rdchk(lpfd_pkg::REG_IRQ_STATUS, 32'h10000, 32'h0);
        wait_cyc(1200);
        rdchk(lpfd_pkg::REG_IRQ_STATUS, 32'h10000, 32'h10000);
        summarize();
    end
endmodule : tb_lowside_pwm_fault_driver
